// >>> design/bpos_consts.svh
// Constants for the bridge PWM output and shutdown stage
//
// Function
// - Forward: A active, D modulated, B/C inactive
// - Reverse: C active, B modulated, A/D inactive
// - Direction bit applies from next PWM cycle
// - Four counts early: B/D off, swap A/C
// - No dead-band in full-bridge mode
// - Per-pair polarity from low mode bits
// - Period flag set as each period begins
// - Three-bit field selects shutdown triggers
// - Firmware writing status one causes shutdown
// - Shutdown sets status bit until cleared
// - Shutdown forces enabled pins to shutdown state
// - Pair A/C shutdown state: low, high, float
// - Pair B/D shutdown state: low, high, float
// - Shutdown trigger is level sensitive
// - Status writes ignored while trigger active
// - Restart resumes modulated output at next period
// - Auto restart clears status when trigger leaves
// - Synced comparator delays shutdown via timer tick
// - Half-bridge dead-band in instruction cycles
// - Count equals instruction cycles of delay, four clocks each
// - Without auto restart firmware clears status
`ifndef BPOS_CONSTS_SVH
`define BPOS_CONSTS_SVH
// Register byte offsets
`define BPOS_ADDR_CTL 5'h00
`define BPOS_ADDR_ASD 5'h04
`define BPOS_ADDR_EPC 5'h08
`define BPOS_ADDR_PIN 5'h0c
`define BPOS_ADDR_STS 5'h10
// Reset values
`define BPOS_RST_CTL 8'h00
`define BPOS_RST_ASD 8'h00
`define BPOS_RST_EPC 8'h00
`define BPOS_RST_PIN 6'h0f
// Field positions
`define BPOS_DIR_BIT 7
`define BPOS_ASE_BIT 7
`define BPOS_RSEN_BIT 7
`define BPOS_SYNC1_BIT 4
`define BPOS_SYNC2_BIT 5
// Timing: lead of the direction swap, Tosc per Tcy
`define BPOS_END_LEAD 8'h04
`define BPOS_TOSC_PER_TCY 4
`define BPOS_TCY_LAST 2'((`BPOS_TOSC_PER_TCY) - 1)
`endif

// >>> design/bpos_pkg.sv
// Types for the bridge PWM output and shutdown stage
package bpos_pkg;
    // Output mode codes of the two high control bits
    typedef enum logic [1:0] {
        BPOS_SINGLE = 2'b00,
        BPOS_FWD    = 2'b01,
        BPOS_HALF   = 2'b10,
        BPOS_REV    = 2'b11
    } bpos_mode_t;

    // Whole state of the block
    typedef struct packed {
        logic [7:0]      ctl;     // capture_compare_pwm_control
        logic [7:0]      asd;     // auto_shutdown_control
        logic [7:0]      epc;     // enhanced_pwm_control
        logic [5:0]      pin;     // pin_direction_latch + sync bits
        logic            tpf;     // timer_period_flag
        logic            dir_act; // direction in force
        logic            hold;    // modulated pins held off
        logic            mod_en;  // modulation allowed
        logic            ase;     // shutdown_event_status
        logic [1:0]      presc;   // Tosc to Tcy divider
        logic [1:0][6:0] db_cnt;  // dead-band counters
        logic [1:0]      db_act;  // delayed half-bridge levels
        logic [2:0]      s1;      // synchroniser stage one
        logic [2:0]      s2;      // synchroniser stage two
        logic [1:0]      c_lat;   // tick-latched comparators
        logic            waitreq; // bus wait
        logic [7:0]      rdata;   // bus read data
        logic [3:0]      out;     // pin levels D..A
        logic [3:0]      oen;     // pin enables, low drives
    } bpos_st_t;
endpackage

// >>> design/bpos_top.sv
// Bridge PWM output steering, polarity, dead-band and shutdown
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "bpos_consts.svh"
module bpos_top
    import bpos_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Period timer, same clock
    input  wire logic        pwm_in,
    input  wire logic        period_start,
    input  wire logic [7:0]  period_timer_count,
    input  wire logic [7:0]  period_register,
    input  wire logic        timer1_tick,
    // Asynchronous trigger inputs
    input  wire logic        comp1_out,
    input  wire logic        comp2_out,
    input  wire logic        ext_shutdown_n,
    // Bridge pins
    output logic             bridge_out_a,
    output logic             bridge_out_a_oe_n,
    output logic             bridge_out_b,
    output logic             bridge_out_b_oe_n,
    output logic             bridge_out_c,
    output logic             bridge_out_c_oe_n,
    output logic             bridge_out_d,
    output logic             bridge_out_d_oe_n
);

    bpos_st_t   r;        // Registered state
    bpos_st_t   n;        // Next state
    bpos_mode_t mode;     // Output mode field
    logic       enh;      // PWM mode selected
    logic       full;     // Full-bridge, either way
    logic       half;     // Half-bridge
    logic       pac;      // Pair A/C active low
    logic       pbd;      // Pair B/D active low
    logic       c1_low;   // Comparator 1 low
    logic       c2_low;   // Comparator 2 low
    logic       ext_low;  // External pin low
    logic       trig;     // Selected trigger level
    logic       sd;       // Shutdown in force
    logic       near_end; // Four counts before end
    logic       pend;     // Direction change waiting
    logic       acc;      // Bus access completes
    logic       wr_ok;    // Write with low lane
    logic       wr_asd;   // Write to shutdown reg
    logic       tcy;      // Instruction-cycle tick
    logic       pwm;      // Gated modulation
    logic [3:0] act;      // Active flags D..A
    logic [1:0] tgt;      // Half-bridge targets
    logic [1:0] ssel;     // Shutdown state of pair

    // Field decode
    assign mode   = bpos_mode_t'(r.ctl[7:6]);
    assign enh    = (r.ctl[3:2] == 2'h3);
    assign full   = (mode == BPOS_FWD) || (mode == BPOS_REV);
    assign half   = (mode == BPOS_HALF);
    assign pac    = r.ctl[1];
    assign pbd    = r.ctl[0];

    // Synced comparators wait for the timer tick copy
    assign c1_low = ~(r.pin[`BPOS_SYNC1_BIT] ? r.c_lat[0] : r.s2[0]);
    assign c2_low = ~(r.pin[`BPOS_SYNC2_BIT] ? r.c_lat[1] : r.s2[1]);
    assign ext_low = ~r.s2[2];

    // Level OR of the enabled sources; 000 disables
    assign trig = |(r.asd[6:4] & {ext_low, c2_low, c1_low});

    // Trigger acts the same cycle it is seen
    assign sd = r.ase | trig;

    // Four timer counts before period end
    assign near_end = (period_timer_count == (period_register - `BPOS_END_LEAD));
    assign pend     = full && (r.ctl[`BPOS_DIR_BIT] != r.dir_act);

    // Bus handshake: one wait cycle per access
    assign acc    = (avs_read | avs_write) & ~r.waitreq;
    assign wr_ok  = avs_write & acc & avs_byteenable[0];
    assign wr_asd = wr_ok && (avs_address == `BPOS_ADDR_ASD);

    // Dead-band ticks every fourth clock
    assign tcy = (r.presc == `BPOS_TCY_LAST);

    // No modulation until a clean period start
    assign pwm = pwm_in & r.mod_en;

    // Next-state logic
    always_comb begin
        n = r;
        act  = 4'h0;
        tgt  = 2'h0;
        ssel = 2'h0;

        // Two-stage synchronisers for pins
        n.s1 = {ext_shutdown_n, comp2_out, comp1_out};
        n.s2 = r.s1;
        // Comparator copy refreshed on timer tick
        if (timer1_tick) begin
            n.c_lat = r.s2[1:0];
        end

        // Divider for instruction cycles
        n.presc = r.presc + 2'h1;

        // Bus: wait high on first cycle
        n.waitreq = ~((avs_read | avs_write) & r.waitreq);
        // Read data captured while waiting
        if (avs_read & r.waitreq) begin
            unique case (avs_address)
                `BPOS_ADDR_CTL: n.rdata = r.ctl;
                `BPOS_ADDR_ASD: n.rdata = {r.ase, r.asd[6:0]};
                `BPOS_ADDR_EPC: n.rdata = r.epc;
                `BPOS_ADDR_PIN: n.rdata = {2'h0, r.pin};
                `BPOS_ADDR_STS: n.rdata = {5'h0, trig, r.dir_act, r.tpf};
                default:        n.rdata = 8'h00;
            endcase
        end

        // Register writes
        if (wr_ok) begin
            unique case (avs_address)
                `BPOS_ADDR_CTL: n.ctl = avs_writedata[7:0];
                `BPOS_ADDR_ASD: n.asd = avs_writedata[7:0];
                `BPOS_ADDR_EPC: n.epc = avs_writedata[7:0];
                `BPOS_ADDR_PIN: n.pin = avs_writedata[5:0];
                // Flag clear by writing one
                `BPOS_ADDR_STS: n.tpf = r.tpf & ~avs_writedata[0];
                default: ;
            endcase
        end
        // Period flag set wins over its clear
        if (period_start && enh) begin
            n.tpf = 1'b1;
        end

        // Shutdown status: trigger first, then write, then restart
        if (trig) begin
            n.ase = 1'b1;
        end else if (wr_asd) begin
            n.ase = avs_writedata[`BPOS_ASE_BIT];
        end else if (r.epc[`BPOS_RSEN_BIT] && r.ase) begin
            n.ase = 1'b0;
        end

        // Modulation gate reopens only at a period start
        if (sd || !enh) begin
            n.mod_en = 1'b0;
        end else if (period_start) begin
            n.mod_en = 1'b1;
        end

        // Direction: hold ends at period start
        if (period_start) begin
            n.hold = 1'b0;
            if (!full) begin
                n.dir_act = r.ctl[`BPOS_DIR_BIT];
            end
        end
        // Swap early, idle modulated pins until period start
        if (near_end && pend) begin
            n.dir_act = r.ctl[`BPOS_DIR_BIT];
            n.hold    = 1'b1;
        end

        // Half-bridge targets, complementary
        tgt[0] = half & pwm;
        tgt[1] = half & r.mod_en & ~pwm_in;
        // Dead-band delays only the rise
        for (int i = 0; i < 2; i++) begin
            if (!tgt[i]) begin
                n.db_act[i] = 1'b0;
                n.db_cnt[i] = 7'h00;
            end else if (!r.db_act[i]) begin
                if (r.db_cnt[i] >= r.epc[6:0]) begin
                    n.db_act[i] = 1'b1;
                end else if (tcy) begin
                    n.db_cnt[i] = r.db_cnt[i] + 7'h01;
                end
            end
        end

        // Active flags per mode
        unique case (mode)
            // Full-bridge gets no dead-band
            BPOS_FWD: begin
                act[0] = ~r.dir_act;
                act[3] = ~r.dir_act & pwm & ~r.hold;
                act[2] = r.dir_act;
                act[1] = r.dir_act & pwm & ~r.hold;
            end
            BPOS_REV: begin
                act[2] = r.dir_act;
                act[1] = r.dir_act & pwm & ~r.hold;
                act[0] = ~r.dir_act;
                act[3] = ~r.dir_act & pwm & ~r.hold;
            end
            BPOS_HALF: begin
                act[0] = n.db_act[0];
                act[1] = n.db_act[1];
            end
            // Single-output steering not built here
            BPOS_SINGLE: act = 4'h0;
        endcase

        // Polarity per pair: active low inverts
        n.out = act ^ {pbd, pac, pbd, pac};
        n.oen = r.pin[3:0] | {4{~enh}};
        // Pins C and D unused in half-bridge
        if (half) begin
            n.oen[3:2] = 2'h3;
        end
        if (mode == BPOS_SINGLE) begin
            n.oen = 4'hf;
        end

        // Shutdown overrides enabled pins only
        if (sd && enh) begin
            ssel = r.asd[3:2];
            n.out[0] = ssel[0];
            n.out[2] = ssel[0];
            n.oen[0] = n.oen[0] | ssel[1];
            n.oen[2] = n.oen[2] | ssel[1];
            ssel = r.asd[1:0];
            n.out[1] = ssel[0];
            n.out[3] = ssel[0];
            n.oen[1] = n.oen[1] | ssel[1];
            n.oen[3] = n.oen[3] | ssel[1];
        end
    end

    // State register, synchronous reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            r         <= '0;
            r.ctl     <= `BPOS_RST_CTL;
            r.asd     <= `BPOS_RST_ASD;
            r.epc     <= `BPOS_RST_EPC;
            r.pin     <= `BPOS_RST_PIN;
            r.waitreq <= 1'b1;
            r.s1      <= 3'h7;
            r.s2      <= 3'h7;
            r.c_lat   <= 2'h3;
            r.oen     <= 4'hf;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state flops
    assign avs_readdata      = {24'h000000, r.rdata};
    assign avs_waitrequest   = r.waitreq;
    assign bridge_out_a      = r.out[0];
    assign bridge_out_a_oe_n = r.oen[0];
    assign bridge_out_b      = r.out[1];
    assign bridge_out_b_oe_n = r.oen[1];
    assign bridge_out_c      = r.out[2];
    assign bridge_out_c_oe_n = r.oen[2];
    assign bridge_out_d      = r.out[3];
    assign bridge_out_d_oe_n = r.oen[3];

    // Checks on the block's own behaviour
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // Forward steady state: A active, B and C inactive
    property p_fwd;
        (mode == BPOS_FWD) && !r.dir_act && !sd && enh
        |=> bridge_out_a == !$past(pac) && bridge_out_c == $past(pac)
            && bridge_out_b == $past(pbd);
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward levels wrong");

    // Reverse steady state: C active, A and D inactive
    property p_rev;
        (mode == BPOS_REV) && r.dir_act && !sd && enh
        |=> bridge_out_c == !$past(pac) && bridge_out_a == $past(pac)
            && bridge_out_d == $past(pbd);
    endproperty
    a_rev: assert property (p_rev) else $error("reverse levels wrong");

    // Direction moves only at end lead or period start
    property p_dir;
        $changed(r.dir_act) |-> $past(near_end || period_start);
    endproperty
    a_dir: assert property (p_dir) else $error("direction changed mid period");

    // Swap step: hold raised, then B and D inactive
    sequence s_swap;
        near_end && pend && !period_start;
    endsequence
    property p_swap;
        s_swap |=> r.hold ##1 (sd || !enh || (bridge_out_b == $past(pbd, 2) && bridge_out_d == $past(pbd, 2)));
    endproperty
    a_swap: assert property (p_swap) else $error("swap did not idle B and D");

    // Trigger sets status, firmware cannot clear it
    property p_trig;
        trig |=> r.ase;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger did not set status");

    // Float code tristates pair A/C next edge
    property p_float;
        sd && enh && r.asd[3] |=> bridge_out_a_oe_n && bridge_out_c_oe_n;
    endproperty
    a_float: assert property (p_float) else $error("pair A/C not floated");

    // Auto restart clears status once trigger is gone
    property p_rst;
        r.ase && !trig && r.epc[7] && !wr_asd |=> !r.ase;
    endproperty
    a_rst: assert property (p_rst) else $error("auto restart failed");

    // Gate stays shut until a period start
    property p_gate;
        !r.mod_en && !period_start |=> !r.mod_en;
    endproperty
    a_gate: assert property (p_gate) else $error("modulation resumed early");

    // Period flag follows period start
    property p_tpf;
        period_start && enh |=> r.tpf [*1] ##0 r.tpf;
    endproperty
    a_tpf: assert property (p_tpf) else $error("period flag not set");

    // Dead-band rise only after full count
    property p_db;
        $rose(r.db_act[0]) |-> $past(r.db_cnt[0]) >= $past(r.epc[6:0]);
    endproperty
    a_db: assert property (p_db) else $error("dead-band too short");

    // Float code tristates pair B/D next edge
    property p_bd_float;
        sd && enh && r.asd[1] |=> bridge_out_b_oe_n && bridge_out_d_oe_n;
    endproperty
    a_bd_float: assert property (p_bd_float) else $error("pair B/D not floated");

    // Enabled pin A takes its programmed level in shutdown
    property p_sd_drive;
        sd && enh && (mode != BPOS_SINGLE) && !r.pin[0] && !r.asd[3]
        |=> !bridge_out_a_oe_n && (bridge_out_a == $past(r.asd[2]));
    endproperty
    a_sd_drive: assert property (p_sd_drive) else $error("pin A not in shutdown state");

    // Unused half-bridge pins stay released, shutdown included
    property p_half_off;
        half && enh |=> bridge_out_c_oe_n && bridge_out_d_oe_n;
    endproperty
    a_half_off: assert property (p_half_off) else $error("unused pin driven");

    // Without auto restart only firmware clears the status
    property p_keep;
        r.ase && !r.epc[`BPOS_RSEN_BIT] && !wr_asd |=> r.ase;
    endproperty
    a_keep: assert property (p_keep) else $error("status cleared without firmware");

    // Forward modulated pin D follows the gate with no delay
    property p_nodb;
        (mode == BPOS_FWD) && !r.dir_act && !r.hold && !sd && enh
        |=> bridge_out_d == ($past(pwm) ^ $past(pbd));
    endproperty
    a_nodb: assert property (p_nodb) else $error("forward pin D delayed");

endmodule

// >>> sim/bpos_bridge_load.sv
// Bridge switch and load model seen from the four pins
`timescale 1ns/1ps
module bpos_bridge_load (
    // Clock and monitor enable
    input  wire logic       mclk,
    input  wire logic       arm,
    // Pins from the bridge stage, D..A
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe_n,
    // Resolved pin levels and overlap count
    output logic      [3:0] pin_lvl,
    output int              overlap
);
    int cnt = 0; // Overlap events seen while armed
    // Released pins fall to the board pull-down, never the last value
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_lvl[i] = pin_oe_n[i] ? 1'b0 : pin_out[i];
        end
    end
    // Both switches of one leg on means shoot-through
    always @(posedge mclk) begin
        if (arm && ((pin_lvl[0] && pin_lvl[1]) || (pin_lvl[2] && pin_lvl[3]))) begin
            cnt <= cnt + 1;
        end
    end
    assign overlap = cnt;
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the bridge output and shutdown stage
`timescale 1ns/1ps
`include "bpos_consts.svh"
module tb_top;
    localparam logic [4:0] R_CTL = `BPOS_ADDR_CTL;
    localparam logic [4:0] R_ASD = `BPOS_ADDR_ASD;
    localparam logic [4:0] R_EPC = `BPOS_ADDR_EPC;
    localparam logic [4:0] R_PIN = `BPOS_ADDR_PIN;
    localparam logic [4:0] R_STS = `BPOS_ADDR_STS;
    localparam logic [7:0] PR    = 8'h1f;     // Short period keeps the run brief
    // Bus and timer stimulus
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [3:0]  avs_byteenable = 4'h1;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  tcnt = 8'h00;
    logic        timer1_tick = 1'b0;
    logic [2:0]  trig = 3'b111;           // Ext, comp2, comp1; low trips
    // Pins and load model view
    logic [3:0]  pout;
    logic [3:0]  poe_n;
    logic [3:0]  plvl;
    logic        arm = 1'b0;
    int          overlap;
    int          bad_count = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          d0;
    int          d3;
    logic [7:0]  asdv [4] = '{8'h80, 8'h85, 8'h8a, 8'h84};
    logic [7:0]  pinv [4] = '{8'h00, 8'h0f, 8'hf0, 8'h05};

    always #20 mclk = ~mclk;

    // Period timer stand-in, pwm high in the first half
    always @(posedge mclk) begin
        if (sys_rst) begin
            tcnt <= 8'h00;
        end else begin
            tcnt <= (tcnt == PR) ? 8'h00 : tcnt + 8'h01;
        end
    end

    bpos_top uut (
        .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pwm_in(tcnt < 8'h10), .period_start(tcnt == 8'h00 && !sys_rst),
        .period_timer_count(tcnt), .period_register(PR), .timer1_tick(timer1_tick),
        .comp1_out(trig[0]), .comp2_out(trig[1]), .ext_shutdown_n(trig[2]),
        .bridge_out_a(pout[0]), .bridge_out_a_oe_n(poe_n[0]),
        .bridge_out_b(pout[1]), .bridge_out_b_oe_n(poe_n[1]),
        .bridge_out_c(pout[2]), .bridge_out_c_oe_n(poe_n[2]),
        .bridge_out_d(pout[3]), .bridge_out_d_oe_n(poe_n[3])
    );

    bpos_bridge_load load (
        .mclk(mclk), .arm(arm), .pin_out(pout), .pin_oe_n(poe_n), .pin_lvl(plvl), .overlap(overlap)
    );

    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard, far above the thousand or so cycles needed
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One Avalon access; held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask

    // Wait until the timer shows a count, then let outputs settle
    task automatic at_cnt(input logic [7:0] v);
        do begin
            @(posedge mclk);
            #1;
        end while (tcnt !== v);
    endtask

    // Cycles from period start to output A going high
    task automatic rise_a(output int d);
        at_cnt(8'h00);
        d = 0;
        while (pout[0] !== 1'b1) begin
            @(posedge mclk);
            #1;
            d++;
        end
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        // Reset values, unmapped place
        chk({poe_n, plvl}, 8'hf0);
        rd(R_CTL, 8'h00);
        rd(R_ASD, 8'h00);
        rd(R_EPC, 8'h00);
        rd(R_PIN, 8'h0f);
        wr(5'h14, 8'hff);
        rd(5'h14, 8'h00);
        $display("test reset done");
        // Forward bridge; dead-band set but must not act
        wr(R_CTL, 8'h4c);
        wr(R_EPC, 8'h03);
        at_cnt(8'h02);
        wr(R_STS, 8'h01);
        rd(R_STS, 8'h00);
        at_cnt(8'h02);
        rd(R_STS, 8'h01);
        wr(R_PIN, 8'h00);
        at_cnt(8'h00);
        arm = 1'b1;
        at_cnt(8'h08);
        chk({4'h0, plvl}, 8'h09);
        at_cnt(8'h18);
        chk({4'h0, plvl}, 8'h01);
        // Reverse requested mid-period; B/D cut and A/C swapped four counts before end
        at_cnt(8'h02);
        wr(R_CTL, 8'hcc);
        at_cnt(8'h08);
        chk({4'h0, plvl}, 8'h09);
        at_cnt(8'h1e);
        chk({4'h0, plvl}, 8'h04);
        at_cnt(8'h08);
        chk({4'h0, plvl}, 8'h06);
        at_cnt(8'h18);
        chk({4'h0, plvl}, 8'h04);
        rd(R_STS, 8'h03);
        $display("test bridge done");
        // Polarity changed only with drivers off
        arm = 1'b0;
        wr(R_PIN, 8'h0f);
        wr(R_CTL, 8'hcf);
        wr(R_PIN, 8'h00);
        at_cnt(8'h00);
        at_cnt(8'h08);
        chk({4'h0, plvl}, 8'h09);
        at_cnt(8'h18);
        chk({4'h0, plvl}, 8'h0b);
        // Firmware shutdown with every pair state
        for (int s = 0; s < 4; s++) begin
            wr(R_ASD, asdv[s]);
            repeat (3) @(posedge mclk);
            #1;
            chk({poe_n, plvl}, pinv[s]);
            rd(R_ASD, asdv[s]);
        end
        // Firmware restart waits for the next period
        at_cnt(8'h02);
        wr(R_ASD, 8'h00);
        at_cnt(8'h0a);
        chk({7'h0, plvl[1]}, 8'h01);
        at_cnt(8'h08);
        chk({4'h0, plvl}, 8'h09);
        $display("test firmware shutdown done");
        // External pin trip without auto restart
        wr(R_ASD, 8'h40);
        @(posedge mclk);
        trig <= 3'b011;
        repeat (5) @(posedge mclk);
        #1;
        chk({poe_n, plvl}, 8'h00);
        rd(R_ASD, 8'hc0);
        wr(R_ASD, 8'h40);
        rd(R_ASD, 8'hc0);
        trig <= 3'b111;
        repeat (6) @(posedge mclk);
        rd(R_ASD, 8'hc0);
        wr(R_ASD, 8'h40);
        rd(R_ASD, 8'h40);
        // Every source code against every trigger, auto restart on
        wr(R_EPC, 8'h80);
        for (int i = 0; i < 8; i++) begin
            for (int t = 0; t < 3; t++) begin
                wr(R_ASD, {1'b0, i[2:0], 4'h0});
                @(posedge mclk);
                trig <= ~(3'b001 << t);
                repeat (5) @(posedge mclk);
                rd(R_ASD, {i[t], i[2:0], 4'h0});
                trig <= 3'b111;
                repeat (5) @(posedge mclk);
                rd(R_ASD, {1'b0, i[2:0], 4'h0});
            end
        end
        // Synced comparator waits for the timer tick
        wr(R_PIN, 8'h10);
        wr(R_ASD, 8'h10);
        @(posedge mclk);
        trig <= 3'b110;
        repeat (8) @(posedge mclk);
        rd(R_ASD, 8'h10);
        timer1_tick <= 1'b1;
        @(posedge mclk);
        timer1_tick <= 1'b0;
        repeat (5) @(posedge mclk);
        rd(R_ASD, 8'h90);
        trig <= 3'b111;
        // Let the release pass the synchroniser before the tick
        repeat (3) @(posedge mclk);
        timer1_tick <= 1'b1;
        @(posedge mclk);
        timer1_tick <= 1'b0;
        repeat (5) @(posedge mclk);
        rd(R_ASD, 8'h10);
        $display("test auto shutdown done");
        // Half-bridge dead-band, three instruction cycles
        wr(R_ASD, 8'h00);
        wr(R_EPC, 8'h00);
        wr(R_PIN, 8'h0f);
        wr(R_CTL, 8'h8c);
        wr(R_PIN, 8'h00);
        at_cnt(8'h00);
        arm = 1'b1;
        rise_a(d0);
        wr(R_EPC, 8'h03);
        rise_a(d3);
        chk({7'h0, (d3 - d0 >= 9) && (d3 - d0 <= 15)}, 8'h01);
        chk({7'h0, overlap == 0}, 8'h01);
        // Shutdown in half-bridge leaves the unused pins released
        arm = 1'b0;
        wr(R_ASD, 8'h85);
        repeat (3) @(posedge mclk);
        #1;
        chk({poe_n, plvl}, 8'hc3);
        $display("test dead band done");
        complete_run();
    end
endmodule
